// >>> count_pin_source.sv
// Model of the external count pins driving the timer pair
`timescale 1ns/1ps
module count_pin_source (
  input  wire logic i_clk,
  output logic      o_pin_a,
  output logic      o_pin_b
);
  initial begin
    o_pin_a = 1'b1;
    o_pin_b = 1'b1;
  end
  task automatic falls(input bit b, input int n);
    repeat (n) begin
      @(posedge i_clk);
      if (b) o_pin_b <= 1'b0; else o_pin_a <= 1'b0;
      repeat (2) @(posedge i_clk);
      if (b) o_pin_b <= 1'b1; else o_pin_a <= 1'b1;
      @(posedge i_clk);
    end
  endtask
endmodule

// >>> dual_legacy_counter_timer.v
// Two legacy 8051-style counter/timers with loose control and status ports
// Contract
// - 16-bit count as low/high bytes
// - Independent mode and clock per timer
// - Timer clock: system or prescaled source
// - Counter increments on count pin falls
// - Count pin edges up to clk/4
// - 13-bit: high byte, low five bits
// - 13-bit wrap sets flag, requests irq
// - Counter select picks count pin falls
// - Scale select: system or scaled clock
// - Timer b mirrors timer a behaviour except split mode, where b holds its count
// - Irq request only when enabled
// - Run bit and gate/pin enable counting; timer b ignores both while a is split
// - Four modes incl. split eight-bit
// - Reload mode reloads low from high
// - Flag cleared by software or vector
`timescale 1ns/1ps
`include "timer_pair_map.vh"
module dual_legacy_counter_timer (
  input  wire       i_clk,
  input  wire       i_rst_b,
  input  wire [7:0] i_timer_mode_register,
  input  wire [1:0] i_timer_scale_select_bits,
  input  wire [1:0] i_clock_scale_bits,
  input  wire       i_ext_prescale_clk,
  input  wire       i_timer_a_run_bit,
  input  wire       i_timer_b_run_bit,
  input  wire       i_timer_a_irq_enable,
  input  wire       i_timer_b_irq_enable,
  input  wire       i_gate_input_a_polarity,
  input  wire       i_gate_input_b_polarity,
  input  wire       i_external_gate_input_a,
  input  wire       i_external_gate_input_b,
  input  wire       i_count_input_pin_a,
  input  wire       i_count_input_pin_b,
  input  wire       i_timer_a_low_wr,
  input  wire       i_timer_a_high_wr,
  input  wire       i_timer_b_low_wr,
  input  wire       i_timer_b_high_wr,
  input  wire [7:0] i_wr_data,
  input  wire       i_timer_a_flag_clr,
  input  wire       i_timer_b_flag_clr,
  input  wire       i_timer_a_vector_ack,
  input  wire       i_timer_b_vector_ack,
  output wire [7:0] o_timer_a_low_byte,
  output wire [7:0] o_timer_a_high_byte,
  output wire [7:0] o_timer_b_low_byte,
  output wire [7:0] o_timer_b_high_byte,
  output wire       o_timer_a_overflow_flag,
  output wire       o_timer_b_overflow_flag,
  output wire       o_timer_a_irq,
  output wire       o_timer_b_irq,
  output wire       o_timer_b_overflow_tick
);
  reg  [7:0] a_low_r;
  reg  [7:0] a_high_r;
  reg  [7:0] b_low_r;
  reg  [7:0] b_high_r;
  reg        a_flag_r;
  reg        b_flag_r;
  reg        b_tick_r;
  reg  [7:0] a_low_nxt;
  reg  [7:0] a_high_nxt;
  reg  [7:0] b_low_nxt;
  reg  [7:0] b_high_nxt;
  reg        a_ovf;
  reg        ah_ovf;
  reg        b_ovf;

  wire       pre_tick;
  wire       gate_a_lvl;
  wire       gate_b_lvl;
  wire       pin_a_fall;
  wire       pin_b_fall;

  wire [1:0] a_mode = i_timer_mode_register[`TMR_MODE_MSB:`TMR_MODE_LSB];
  wire [1:0] b_mode = i_timer_mode_register[`TMR_B_NIBBLE_LSB +
                      `TMR_MODE_MSB:`TMR_B_NIBBLE_LSB];
  wire       a_csel = i_timer_mode_register[`TMR_CSEL_BIT];
  wire       b_csel = i_timer_mode_register[`TMR_B_NIBBLE_LSB +
                      `TMR_CSEL_BIT];
  wire       a_gate = i_timer_mode_register[`TMR_GATE_BIT];
  wire       b_gate = i_timer_mode_register[`TMR_B_NIBBLE_LSB +
                      `TMR_GATE_BIT];
  wire       a_split = (a_mode == `TMR_MODE_SPLIT);

  prescale_gen u_prescale (
    .i_clk     (i_clk),
    .i_rst_b   (i_rst_b),
    .i_scale   (i_clock_scale_bits),
    .i_ext_clk (i_ext_prescale_clk),
    .o_tick    (pre_tick)
  );

  // edge detect at full clock rate
  pin_edge_sync u_cnt_a (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_pin   (i_count_input_pin_a),
    .o_level (),
    .o_fall  (pin_a_fall)
  );

  pin_edge_sync u_cnt_b (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_pin   (i_count_input_pin_b),
    .o_level (),
    .o_fall  (pin_b_fall)
  );

  pin_edge_sync u_gate_a (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_pin   (i_external_gate_input_a),
    .o_level (gate_a_lvl),
    .o_fall  ()
  );

  pin_edge_sync u_gate_b (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_pin   (i_external_gate_input_b),
    .o_level (gate_b_lvl),
    .o_fall  ()
  );

  wire a_clk_tick = i_timer_scale_select_bits[0] ? 1'b1 : pre_tick;
  wire b_clk_tick = i_timer_scale_select_bits[1] ? 1'b1 : pre_tick;

  wire a_run = i_timer_a_run_bit &
               (~a_gate | (gate_a_lvl == i_gate_input_a_polarity));
  wire b_run_norm = i_timer_b_run_bit &
               (~b_gate | (gate_b_lvl == i_gate_input_b_polarity));

  wire a_inc = a_run & (a_csel ? pin_a_fall : a_clk_tick);
  // Split high half is timer-only, run by timer b run bit
  wire ah_inc = i_timer_b_run_bit & a_clk_tick;
  // Timer b cannot use its pin while timer a is split
  wire b_inc = (b_mode != `TMR_MODE_SPLIT) &
               (a_split ? b_clk_tick :
                (b_run_norm & (b_csel ? pin_b_fall : b_clk_tick)));

  always @* begin
    a_low_nxt  = a_low_r;
    a_high_nxt = a_high_r;
    a_ovf      = 1'b0;
    ah_ovf     = 1'b0;
    if (a_inc) begin
      case (a_mode)
        // five low bits then high byte
        `TMR_MODE_13BIT: begin
          a_low_nxt = {a_low_r[7:5], a_low_r[`LOW5_MSB:0] + 5'h01};
          if (a_low_r[`LOW5_MSB:0] == `LOW5_ALLONES) begin
            a_high_nxt = a_high_r + 8'h01;
            a_ovf = (a_high_r == `BYTE_ALLONES);
          end
        end
        `TMR_MODE_16BIT: begin
          {a_high_nxt, a_low_nxt} = {a_high_r, a_low_r} + 16'h0001;
          a_ovf = ({a_high_r, a_low_r} == 16'hFFFF);
        end
        `TMR_MODE_RELOAD: begin
          a_ovf = (a_low_r == `BYTE_ALLONES);
          a_low_nxt = a_ovf ? a_high_r : a_low_r + 8'h01;
        end
        `TMR_MODE_SPLIT: begin
          a_low_nxt = a_low_r + 8'h01;
          a_ovf = (a_low_r == `BYTE_ALLONES);
        end
        default: a_low_nxt = a_low_r;
      endcase
    end
    if (a_split && ah_inc) begin
      a_high_nxt = a_high_r + 8'h01;
      ah_ovf = (a_high_r == `BYTE_ALLONES);
    end
  end

  always @* begin
    b_low_nxt  = b_low_r;
    b_high_nxt = b_high_r;
    b_ovf      = 1'b0;
    if (b_inc) begin
      case (b_mode)
        `TMR_MODE_13BIT: begin
          b_low_nxt = {b_low_r[7:5], b_low_r[`LOW5_MSB:0] + 5'h01};
          if (b_low_r[`LOW5_MSB:0] == `LOW5_ALLONES) begin
            b_high_nxt = b_high_r + 8'h01;
            b_ovf = (b_high_r == `BYTE_ALLONES);
          end
        end
        `TMR_MODE_16BIT: begin
          {b_high_nxt, b_low_nxt} = {b_high_r, b_low_r} + 16'h0001;
          b_ovf = ({b_high_r, b_low_r} == 16'hFFFF);
        end
        `TMR_MODE_RELOAD: begin
          b_ovf = (b_low_r == `BYTE_ALLONES);
          b_low_nxt = b_ovf ? b_high_r : b_low_r + 8'h01;
        end
        default: b_low_nxt = b_low_r;
      endcase
    end
  end

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      a_low_r  <= `BYTE_ZERO;
      a_high_r <= `BYTE_ZERO;
      b_low_r  <= `BYTE_ZERO;
      b_high_r <= `BYTE_ZERO;
      b_tick_r <= 1'b0;
    end else begin
      a_low_r  <= i_timer_a_low_wr  ? i_wr_data : a_low_nxt;
      a_high_r <= i_timer_a_high_wr ? i_wr_data : a_high_nxt;
      b_low_r  <= i_timer_b_low_wr  ? i_wr_data : b_low_nxt;
      b_high_r <= i_timer_b_high_wr ? i_wr_data : b_high_nxt;
      // Still usable as a baud tick while a is split
      b_tick_r <= b_ovf;
    end
  end

  // Timer b flag is owned by the split high half in split mode
  wire b_flag_set = a_split ? ah_ovf : b_ovf;

  // clear by software or vector; set wins
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      a_flag_r <= 1'b0;
      b_flag_r <= 1'b0;
    end else begin
      if (a_ovf)
        a_flag_r <= 1'b1;
      else if (i_timer_a_flag_clr | i_timer_a_vector_ack)
        a_flag_r <= 1'b0;
      if (b_flag_set)
        b_flag_r <= 1'b1;
      else if (i_timer_b_flag_clr | i_timer_b_vector_ack)
        b_flag_r <= 1'b0;
    end
  end

  assign o_timer_a_low_byte      = a_low_r;
  assign o_timer_a_high_byte     = a_high_r;
  assign o_timer_b_low_byte      = b_low_r;
  assign o_timer_b_high_byte     = b_high_r;
  assign o_timer_a_overflow_flag = a_flag_r;
  assign o_timer_b_overflow_flag = b_flag_r;
  assign o_timer_b_overflow_tick = b_tick_r;
  assign o_timer_a_irq = a_flag_r & i_timer_a_irq_enable;
  assign o_timer_b_irq = b_flag_r & i_timer_b_irq_enable;
endmodule

// >>> pin_edge_sync.v
// Two-stage synchroniser with falling edge detect for one input pin
`timescale 1ns/1ps
module pin_edge_sync (
  input  wire i_clk,
  input  wire i_rst_b,
  input  wire i_pin,
  output wire o_level,
  output wire o_fall
);
  reg meta_r;
  reg sync_r;
  reg prev_r;

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      meta_r <= i_pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign o_level = sync_r;
  assign o_fall  = prev_r & ~sync_r;
endmodule

// >>> prescale_gen.v
// Prescaled clock enable generator for the timer pair
`timescale 1ns/1ps
`include "timer_pair_map.vh"
module prescale_gen (
  input  wire       i_clk,
  input  wire       i_rst_b,
  input  wire [1:0] i_scale,
  input  wire       i_ext_clk,
  output wire       o_tick
);
  reg  [5:0] div_r;
  reg  [2:0] ext_cnt_r;
  reg        ext_meta_r;
  reg        ext_sync_r;
  reg        ext_prev_r;
  reg        ext_tick_r;
  wire       ext_rise;
  wire       hit12;
  wire       hit4;
  wire       hit48;

  assign ext_rise = ext_sync_r & ~ext_prev_r;
  assign hit48 = (div_r == `DIV48_LAST);
  assign hit12 = (div_r == `DIV12_LAST1) ||
                 (div_r == `DIV12_LAST2) ||
                 (div_r == `DIV12_LAST3) || hit48;
  assign hit4  = (div_r[1:0] == `DIV4_LAST);

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_r      <= 6'h00;
      ext_cnt_r  <= 3'h0;
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      ext_prev_r <= 1'b0;
      ext_tick_r <= 1'b0;
    end else begin
      div_r      <= hit48 ? 6'h00 : div_r + 6'h01;
      ext_meta_r <= i_ext_clk;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
      ext_tick_r <= 1'b0;
      if (ext_rise) begin
        ext_cnt_r <= ext_cnt_r + 3'h1;
        if (ext_cnt_r == `EXT8_LAST)
          ext_tick_r <= 1'b1;
      end
    end
  end

  assign o_tick = (i_scale == `SCALE_DIV12) ? hit12 :
                  (i_scale == `SCALE_DIV4)  ? hit4  :
                  (i_scale == `SCALE_DIV48) ? hit48 : ext_tick_r;
endmodule

// >>> tb_top.sv
// Self-checking bench for the dual counter/timer block
`timescale 1ns/1ps
module tb_top;
  logic i_clk, i_rst_b, i_ext_prescale_clk, i_timer_a_run_bit;
  logic i_timer_b_run_bit, i_timer_a_irq_enable, i_timer_b_irq_enable;
  logic i_gate_input_a_polarity, i_gate_input_b_polarity;
  logic i_external_gate_input_a, i_external_gate_input_b;
  logic i_count_input_pin_a, i_count_input_pin_b, i_timer_a_low_wr;
  logic i_timer_a_high_wr, i_timer_b_low_wr, i_timer_b_high_wr;
  logic i_timer_a_flag_clr, i_timer_b_flag_clr, i_timer_a_vector_ack;
  logic i_timer_b_vector_ack;
  logic [7:0] i_timer_mode_register, i_wr_data;
  logic [1:0] i_timer_scale_select_bits, i_clock_scale_bits;
  wire [7:0] o_timer_a_low_byte, o_timer_a_high_byte;
  wire [7:0] o_timer_b_low_byte, o_timer_b_high_byte;
  wire o_timer_a_overflow_flag, o_timer_b_overflow_flag, o_timer_a_irq;
  wire o_timer_b_irq, o_timer_b_overflow_tick;
  wire [15:0] cnt_a = {o_timer_a_high_byte, o_timer_a_low_byte};
  wire [15:0] cnt_b = {o_timer_b_high_byte, o_timer_b_low_byte};
  wire [1:0] flg = {o_timer_b_overflow_flag, o_timer_a_overflow_flag};
  wire [1:0] irq = {o_timer_b_irq, o_timer_a_irq};
  int failures, n_checks;
  dual_legacy_counter_timer uut (.*);
  count_pin_source src (.i_clk(i_clk), .o_pin_a(i_count_input_pin_a),
    .o_pin_b(i_count_input_pin_b));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] ex);
    n_checks++;
    if (seen !== ex) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task wr(input bit t, input logic [7:0] hi, input logic [7:0] lo);
    @(posedge i_clk);
    i_wr_data <= lo;
    if (t) i_timer_b_low_wr <= 1'b1; else i_timer_a_low_wr <= 1'b1;
    @(posedge i_clk);
    i_wr_data <= hi;
    {i_timer_b_low_wr, i_timer_a_low_wr} <= 2'h0;
    if (t) i_timer_b_high_wr <= 1'b1; else i_timer_a_high_wr <= 1'b1;
    @(posedge i_clk);
    {i_timer_b_high_wr, i_timer_a_high_wr} <= 2'h0;
  endtask
  // Run mask m for exactly n sampling edges, then let the pipeline settle
  task run(input logic [1:0] m, input int n);
    @(posedge i_clk);
    {i_timer_b_run_bit, i_timer_a_run_bit} <= m;
    repeat (n) @(posedge i_clk);
    {i_timer_b_run_bit, i_timer_a_run_bit} <= 2'h0;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    give_verdict;
  end
  initial begin
    {i_ext_prescale_clk, i_timer_a_run_bit, i_timer_b_run_bit} = 3'h0;
    {i_gate_input_a_polarity, i_gate_input_b_polarity} = 2'h3;
    {i_external_gate_input_a, i_external_gate_input_b} = 2'h3;
    {i_timer_a_low_wr, i_timer_a_high_wr, i_timer_b_low_wr} = 3'h0;
    {i_timer_b_high_wr, i_timer_a_flag_clr, i_timer_b_flag_clr} = 3'h0;
    {i_timer_a_vector_ack, i_timer_b_vector_ack} = 2'h0;
    {i_timer_a_irq_enable, i_timer_b_irq_enable} = 2'h3;
    i_timer_mode_register = 8'h00;
    i_wr_data = 8'h00;
    i_timer_scale_select_bits = 2'h3;
    i_clock_scale_bits = 2'h0;
    i_rst_b = 1'b0;
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(negedge i_clk);
    chk("reset", {cnt_a[7:0], cnt_b[7:0]} | {14'h0, flg}, 16'h0000);
    for (int t = 0; t < 2; t++) begin
      wr(t, 8'hFF, 8'hFE);
      run(t ? 2'h2 : 2'h1, 2);
      chk("wrap13", (t ? cnt_b : cnt_a) & 16'hFF1F, 16'h0000);
      chk("flag13", {15'h0, flg[t]}, 16'h0001);
      chk("irq on", {15'h0, irq[t]}, 16'h0001);
      @(posedge i_clk);
      {i_timer_a_irq_enable, i_timer_b_irq_enable} <= 2'h0;
      @(negedge i_clk);
      chk("irq masked", {14'h0, irq}, 16'h0000);
      @(posedge i_clk);
      {i_timer_a_irq_enable, i_timer_b_irq_enable} <= 2'h3;
      {i_timer_a_vector_ack, i_timer_b_flag_clr} <= 2'h3;
      {i_timer_a_flag_clr, i_timer_b_vector_ack} <= 2'h3;
      @(posedge i_clk);
      {i_timer_a_vector_ack, i_timer_b_flag_clr} <= 2'h0;
      {i_timer_a_flag_clr, i_timer_b_vector_ack} <= 2'h0;
      @(negedge i_clk);
      chk("flag clear", {15'h0, flg[t]}, 16'h0000);
    end
    @(posedge i_clk);
    i_timer_mode_register <= 8'h02;
    wr(0, 8'h80, 8'hFF);
    run(2'h1, 3);
    chk("reload", {cnt_a[15:1], flg[0]}, 16'h8083);
    @(posedge i_clk);
    i_timer_mode_register <= 8'h01;
    wr(0, 8'h00, 8'hFF);
    run(2'h1, 1);
    chk("carry16", cnt_a, 16'h0100);
    // Prescaled a beside system-clocked b
    @(posedge i_clk);
    i_timer_mode_register <= 8'h11;
    i_timer_scale_select_bits <= 2'h2;
    for (int s = 0; s < 3; s++) begin
      i_clock_scale_bits <= s[1:0];
      wr(0, 8'h00, 8'h00);
      wr(1, 8'h00, 8'h00);
      run(2'h3, 48);
      chk("prescale", cnt_a, (s == 0) ? 16'h4 : (s == 1) ? 16'hC : 16'h1);
      chk("sysclk b", cnt_b, 16'h0030);
    end
    // Ext source: sixteen rises give two ticks
    @(posedge i_clk);
    i_clock_scale_bits <= 2'h3;
    wr(0, 8'h00, 8'h00);
    @(posedge i_clk);
    i_timer_a_run_bit <= 1'b1;
    repeat (16) begin
      repeat (2) @(posedge i_clk);
      i_ext_prescale_clk <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_ext_prescale_clk <= 1'b0;
    end
    repeat (6) @(posedge i_clk);
    i_timer_a_run_bit <= 1'b0;
    @(negedge i_clk);
    chk("ext prescale", cnt_a, 16'h0002);
    @(posedge i_clk);
    i_timer_mode_register <= 8'h0D;
    i_external_gate_input_a <= 1'b0;
    wr(0, 8'h00, 8'h00);
    @(posedge i_clk);
    i_timer_a_run_bit <= 1'b1;
    src.falls(0, 5);
    repeat (6) @(negedge i_clk);
    chk("gate closed", cnt_a, 16'h0000);
    @(posedge i_clk);
    i_external_gate_input_a <= 1'b1;
    repeat (4) @(posedge i_clk);
    src.falls(0, 5);
    repeat (6) @(negedge i_clk);
    chk("pin falls", cnt_a, 16'h0005);
    i_timer_a_run_bit <= 1'b0;
    give_verdict;
  end
endmodule

// >>> timer_pair_checker_assertions.sv
// Port-level checker for the dual counter/timer block
`timescale 1ns/1ps
module timer_pair_checker (
  input wire logic       i_clk,
  input wire logic       i_rst_b,
  input wire logic [7:0] i_timer_mode_register,
  input wire logic [1:0] i_timer_scale_select_bits,
  input wire logic       i_timer_a_run_bit,
  input wire logic       i_timer_b_run_bit,
  input wire logic       i_timer_a_irq_enable,
  input wire logic       i_timer_b_irq_enable,
  input wire logic       i_timer_a_low_wr,
  input wire logic       i_timer_a_high_wr,
  input wire logic       i_timer_b_low_wr,
  input wire logic       i_timer_b_high_wr,
  input wire logic [7:0] i_wr_data,
  input wire logic       i_timer_b_flag_clr,
  input wire logic       i_timer_a_vector_ack,
  input wire logic [7:0] o_timer_a_low_byte,
  input wire logic [7:0] o_timer_a_high_byte,
  input wire logic [7:0] o_timer_b_low_byte,
  input wire logic [7:0] o_timer_b_high_byte,
  input wire logic       o_timer_a_overflow_flag,
  input wire logic       o_timer_b_overflow_flag,
  input wire logic       o_timer_a_irq,
  input wire logic       o_timer_b_irq,
  input wire logic       o_timer_b_overflow_tick
);
  wire [15:0] ca = {o_timer_a_high_byte, o_timer_a_low_byte};
  wire [15:0] cb = {o_timer_b_high_byte, o_timer_b_low_byte};
  wire        wa = i_timer_a_low_wr | i_timer_a_high_wr;
  wire        wb = i_timer_b_low_wr | i_timer_b_high_wr;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  a_irq_a_gate: assert property (o_timer_a_irq ==
    (o_timer_a_overflow_flag && i_timer_a_irq_enable)) else $error("irq a");
  a_irq_b_gate: assert property (o_timer_b_irq ==
    (o_timer_b_overflow_flag && i_timer_b_irq_enable)) else $error("irq b");
  a_ack_clears_a: assert property (i_timer_a_vector_ack &&
    !i_timer_a_run_bit |=> !o_timer_a_overflow_flag) else $error("ack a");
  a_clr_clears_b: assert property (i_timer_b_flag_clr &&
    !i_timer_b_run_bit |=> !o_timer_b_overflow_flag) else $error("clr b");
  a_stop_holds_a: assert property (!i_timer_a_run_bit && !wa &&
    i_timer_mode_register[1:0] != 2'h3 |=> $stable(ca)) else $error("hold");
  a_low_write_a: assert property (i_timer_a_low_wr |=>
    o_timer_a_low_byte == $past(i_wr_data)) else $error("write low a");
  a_high_write_b: assert property (i_timer_b_high_wr |=>
    o_timer_b_high_byte == $past(i_wr_data)) else $error("write high b");
  a_sys_step_b: assert property (i_timer_mode_register[7:4] == 4'h1 &&
    i_timer_scale_select_bits[1] && i_timer_b_run_bit && !wb &&
    cb != 16'hFFFF |=> cb == $past(cb) + 16'h0001) else $error("step b");
  a_wrap_flag_a: assert property (i_timer_mode_register[3:0] == 4'h0 &&
    i_timer_scale_select_bits[0] && i_timer_a_run_bit && !wa &&
    ca[15:8] == 8'hFF && ca[4:0] == 5'h1F |=> o_timer_a_overflow_flag &&
    ca[15:8] == 8'h00 && ca[4:0] == 5'h00) else $error("wrap a");
  a_tick_with_flag: assert property ($rose(o_timer_b_overflow_flag) &&
    i_timer_mode_register[1:0] != 2'h3 |-> o_timer_b_overflow_tick)
    else $error("tick b");
endmodule
bind dual_legacy_counter_timer timer_pair_checker chk (.*);

// >>> timer_pair_map.vh
// Field positions, encodings and prescale constants for the timer pair
`ifndef TIMER_PAIR_MAP_VH
`define TIMER_PAIR_MAP_VH
// Mode register fields, per 4-bit timer nibble
`define TMR_MODE_LSB      0
`define TMR_MODE_MSB      1
`define TMR_CSEL_BIT      2
`define TMR_GATE_BIT      3
`define TMR_B_NIBBLE_LSB  4
// Mode encodings
`define TMR_MODE_13BIT    2'h0
`define TMR_MODE_16BIT    2'h1
`define TMR_MODE_RELOAD   2'h2
`define TMR_MODE_SPLIT    2'h3
// Clock scale encodings
`define SCALE_DIV12       2'h0
`define SCALE_DIV4        2'h1
`define SCALE_DIV48       2'h2
`define SCALE_EXT8        2'h3
`define DIV12_COUNT       12
`define DIV4_COUNT        4
`define DIV48_COUNT       48
`define EXT8_COUNT        8
// Terminal counts of the shared divider and the external counter, sized to the bits compared
`define DIV12_LAST1       6'h0B
`define DIV12_LAST2       6'h17
`define DIV12_LAST3       6'h23
`define DIV48_LAST        6'h2F
`define DIV4_LAST         2'h3
`define EXT8_LAST         3'h7
// 13-bit layout
`define LOW5_MSB          4
`define LOW5_ALLONES      5'h1F
`define BYTE_ALLONES      8'hFF
`define BYTE_ZERO         8'h00
`define HIGH_BYTE_LSB     8
`endif
